/* bench/sadc_analog_model.sv */
// Behavioural sample-hold and comparator in front of the converter
`timescale 1ns/1ps
module sadc_analog_model (
  // Clock
  input wire logic clk,
  // Converter side
  input wire logic [9:0] dac_code,
  input wire logic sample,
  input wire logic ladder,
  // Stimulus side
  input wire logic [9:0] level,
  output logic comp
);
  logic [9:0] held_reg = 10'h000;
  logic wobble_reg = 1'b0;

  always @(posedge clk) begin
    wobble_reg <= ~wobble_reg;
    if (sample) begin
      held_reg <= level;
    end
  end

  // No reference means no valid decision, so never a steady answer
  assign comp = ladder ? (held_reg >= dac_code) : wobble_reg;
endmodule

/* bench/sadc_ctrl_test.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module sadc_ctrl_test
  import sadc_pkg::*;
;
  localparam int T_CLK = 25;
  localparam int LIMIT = 30000;
  localparam logic [31:0] A_CR1 = {22'h0, IDX_CTRL_ONE, 2'b00};
  localparam logic [31:0] A_CR2 = {22'h0, IDX_CTRL_TWO, 2'b00};
  localparam logic [31:0] A_HIGH = {22'h0, IDX_RES_HIGH, 2'b00};
  localparam logic [31:0] A_LOW = {22'h0, IDX_RES_LOW, 2'b00};
  localparam logic [31:0] A_BAD = 32'h00000200;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic stop_mode = 1'b0;
  logic [9:0] level = 10'h000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, comp, sample, aind, ladder, irq;
  logic [9:0] dac;
  logic [3:0] chan;
  logic [31:0] seed = 32'h15239910;
  logic [9:0] prev = 10'h000;
  logic [9:0] e;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  time t0;

  sadc_ctrl sadc_ctrl_i (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .STOP_MODE(stop_mode), .COMP_IN(comp), .DAC_CODE(dac),
    .SAMPLE_HOLD(sample), .CHANNEL_SEL(chan), .ANALOG_INPUT_DISABLE(aind), .LADDER_CONNECT(ladder),
    .CONV_DONE_IRQ(irq));

  sadc_analog_model sadc_analog_model_i (.clk(clock), .dac_code(dac), .sample(sample), .ladder(ladder),
    .level(level), .comp(comp));

  initial begin
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [9:0] sar_code(input logic [9:0] v);
    logic [9:0] t;
    t = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      if (v >= (t | (10'h001 << i))) begin
        t = t | (10'h001 << i);
      end
    end
    return t;
  endfunction

  function automatic int conv_len(input logic [2:0] tc);
    case (tc)
      3'h2: return CONV_FC_T2;
      3'h3: return CONV_FC_T3;
      3'h4: return CONV_FC_T4;
      3'h5: return CONV_FC_T5;
      default: return CONV_FC_T6;
    endcase
  endfunction

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: register byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: pin level %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      error_cnt++;
      $display("Error at %0t: cycle count %0d, expected %0d", $time, got, exp);
    end
  endtask

  // One single transfer, then one idle cycle before the next
  task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata[7:0];
    @(posedge clock);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus_xfer(1'b0, a, 8'h00, q);
    chk_reg(q, exp);
  endtask

  task automatic wait_irq(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (irq !== 1'b1 && k < lim);
  endtask

  task automatic run_one(input logic [2:0] tc, input logic rd_hi);
    logic [3:0] ch;
    int k;
    seed = lfsr(seed);
    level <= seed[9:0];
    e = sar_code(seed[9:0]);
    ch = seed[13:10] % 4'h6;
    wr(A_CR2, {2'b00, 2'b01, tc, 1'b0});
    wr(A_CR1, {1'b1, MODE_SOFTWARE, 1'b0, ch});
    // Write landed one edge ago; this edge starts the run
    t0 = $time;
    chk_reg({4'h0, chan}, {4'h0, ch});
    rd_chk(A_CR1, {1'b0, MODE_SOFTWARE, 1'b0, ch});
    rd_chk(A_LOW, {prev[1:0], 2'b01, 4'h0});
    wait_irq(1400, k);
    chk_cnt(int'(($time - t0) / T_CLK), conv_len(tc) + 2);
    chk_pin(irq, 1'b1);
    @(posedge clock);
    chk_pin(irq, 1'b0);
    rd_chk(A_LOW, {e[1:0], 2'b10, 4'h0});
    if (rd_hi) begin
      rd_chk(A_HIGH, e[9:2]);
      rd_chk(A_LOW, {e[1:0], 2'b00, 4'h0});
    end
    prev = e;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd_chk(A_LOW, RES_RESET);
    rd_chk(A_HIGH, RES_RESET);
    wr(A_LOW, 8'hFF);
    rd_chk(A_LOW, 8'h00);
    rd_chk(A_BAD, 8'h00);
    chk_pin(hresp, 1'b0);
    $display("Test reset and map finished");
    // Time code 3 leaves the high result unread before the next start
    for (int c = 0; c < 8; c++) begin
      run_one(3'(c), c != 3);
    end
    $display("Test software start finished");
    for (int m = 0; m < 3; m += 2) begin
      wr(A_CR1, {1'b1, 2'(m), 1'b0, 4'h0});
      wait_irq(300, n);
      chk_pin(irq, 1'b0);
    end
    wr(A_CR1, CR1_RESET);
    $display("Test idle modes finished");
    seed = lfsr(seed);
    level <= seed[9:0];
    wr(A_CR2, 8'h14);
    wr(A_CR1, {1'b1, MODE_REPEAT, 1'b0, 4'h1});
    wait_irq(1400, n);
    t0 = $time;
    seed = lfsr(seed);
    level <= seed[9:0];
    e = sar_code(seed[9:0]);
    wait_irq(1400, n);
    chk_cnt(int'(($time - t0) / T_CLK), CONV_FC_T2 + 2);
    level <= ~seed[9:0];
    rd_chk(A_HIGH, e[9:2]);
    // Abort lands mid-conversion, partial code must not show
    wr(A_CR1, {1'b0, MODE_DISABLE, 1'b0, 4'h1});
    wait_irq(300, n);
    chk_pin(irq, 1'b0);
    rd_chk(A_LOW, {e[1:0], 2'b00, 4'h0});
    rd_chk(A_HIGH, e[9:2]);
    $display("Test repeat and abort finished");
    wr(A_CR2, 8'h3C);
    wr(A_CR1, {1'b1, MODE_SOFTWARE, 1'b0, 4'h2});
    repeat (100) @(posedge clock);
    chk_pin(ladder, 1'b1);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk_pin(ladder, 1'b0);
    chk_pin(aind, CR1_RESET[CR1_INDIS_BIT]);
    wr(A_CR1, 8'hA3);
    rd_chk(A_CR1, CR1_RESET);
    rd_chk(A_CR2, 8'h10);
    rd_chk(A_LOW, 8'h00);
    rd_chk(A_HIGH, 8'h00);
    stop_mode <= 1'b0;
    wait_irq(1300, n);
    chk_pin(irq, 1'b0);
    rd_chk(A_LOW, 8'h00);
    $display("Test stop entry finished");
    summarize();
  end
endmodule

/* core/sadc_ctrl.sv */
// Control, status and AHB-Lite register file of the 10-bit SAR converter
//
// Functional notes
// - Low/status: result bits, done, busy flags
// - Reading high result clears done flag
// - Busy set on start, cleared at end/STOP
// - Low/status bits 3..0 undefined on read
// - Software mode: start bit begins one conversion
// - Completion stores result, sets flag, interrupts
// - Start bit self-clears once conversion starts
// - Repeat mode restarts after each completion
// - Disable aborts; partial result not stored
// - New start clears flag, keeps old result
// - STOP aborts, resets controls, loses results
// - No automatic restart after leaving STOP
// - Ladder disconnected while in STOP
// - Each conversion yields 10-bit unsigned code
// - Result only after selected conversion time
// - Mode: 00 off, 01 software, 11 repeat
// - Time codes 010..110 select 78..1248 periods
// - High result register holds bits 9..2
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int unsigned RES_W = RESULT_W
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Power mode
  input wire logic STOP_MODE,
  // Analog front end
  input wire logic COMP_IN,
  output logic [RES_W-1:0] DAC_CODE,
  output logic SAMPLE_HOLD,
  output logic [3:0] CHANNEL_SEL,
  output logic ANALOG_INPUT_DISABLE,
  output logic LADDER_CONNECT,
  // Interrupt request to the CPU
  output logic CONV_DONE_IRQ
);

  if (RES_W != RESULT_W) begin : g_bad_width
    $error("sadc_ctrl: register layout serves a 10-bit result only");
  end

  // Bus state
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  // Control fields
  logic start_req_reg, rep_pend_reg, indis_reg, ladder_reg;
  logic [1:0] mode_reg;
  logic [3:0] chan_reg;
  logic [2:0] time_reg;
  // Status and results
  logic eoc_reg, irq_reg, ladder_on_reg;
  logic [RES_W-1:0] result_reg;
  // Sequencer
  logic seq_busy, seq_done, seq_sample;
  logic [RES_W-1:0] seq_result, seq_dac;

  // Address decode and write qualification
  wire bus_take = HSEL && HTRANS[1] && HREADY;
  wire [7:0] addr_idx = HADDR[9:2];
  wire rd_take = bus_take && !HWRITE;
  wire [7:0] wbyte = HWDATA[7:0];
  wire wr_cr1 = wr_pend_reg && wr_idx_reg == IDX_CTRL_ONE && !STOP_MODE;
  wire wr_cr2 = wr_pend_reg && wr_idx_reg == IDX_CTRL_TWO && !STOP_MODE;
  wire [1:0] wmode = wbyte[CR1_MODE_LSB +: 2];
  wire rd_high = rd_take && addr_idx == IDX_RES_HIGH;

  wire mode_ok = (mode_reg == MODE_SOFTWARE) || (mode_reg == MODE_REPEAT);
  wire abort = seq_busy && (STOP_MODE || (wr_cr1 && wmode == MODE_DISABLE));
  wire go_req = (start_req_reg && mode_ok) || (rep_pend_reg && mode_reg == MODE_REPEAT);
  wire start_fire = go_req && !seq_busy && !STOP_MODE && !wr_cr1;
  wire store = seq_done && !STOP_MODE;
  wire [CONV_CNT_W-1:0] total_cyc = conv_cycles(time_reg);

  wire [7:0] low_byte = {result_reg[1:0], eoc_reg, seq_busy, 4'h0};
  wire [7:0] high_byte = result_reg[RES_W-1:2];
  wire [7:0] cr1_byte = {start_req_reg, mode_reg, indis_reg, chan_reg};
  wire [7:0] cr2_byte = {2'b00, ladder_reg, 1'b1, time_reg, 1'b0};
  wire [7:0] rd_byte = (addr_idx == IDX_CTRL_ONE) ? cr1_byte :
                       (addr_idx == IDX_CTRL_TWO) ? cr2_byte :
                       (addr_idx == IDX_RES_HIGH) ? high_byte :
                       (addr_idx == IDX_RES_LOW) ? low_byte : 8'h00;

  // Zero wait states: read data is latched at the address phase edge
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      wr_pend_reg <= bus_take && HWRITE;
      if (bus_take) begin
        wr_idx_reg <= addr_idx;
      end
      if (rd_take) begin
        hrdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control register one
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      {start_req_reg, mode_reg, indis_reg, chan_reg} <= CR1_RESET;
      rep_pend_reg <= 1'b0;
    end else if (STOP_MODE) begin
      {start_req_reg, mode_reg, indis_reg, chan_reg} <= CR1_RESET;
      rep_pend_reg <= 1'b0;
    end else begin
      if (wr_cr1) begin
        start_req_reg <= wbyte[CR1_START_BIT];
        mode_reg <= wmode;
        indis_reg <= wbyte[CR1_INDIS_BIT];
        chan_reg <= wbyte[CR1_CHAN_LSB +: 4];
      end else if (start_fire) begin
        start_req_reg <= 1'b0;
      end
      if (seq_done && mode_reg == MODE_REPEAT && !abort) begin
        rep_pend_reg <= 1'b1;
      end else if (start_fire || (wr_cr1 && wmode != MODE_REPEAT)) begin
        rep_pend_reg <= 1'b0;
      end
    end
  end

  // Control register two; fixed bits are not stored
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ladder_reg <= CR2_RESET[CR2_LADDER_BIT];
      time_reg <= CR2_RESET[CR2_TIME_LSB +: 3];
    end else if (STOP_MODE) begin
      ladder_reg <= CR2_RESET[CR2_LADDER_BIT];
      time_reg <= CR2_RESET[CR2_TIME_LSB +: 3];
    end else if (wr_cr2) begin
      ladder_reg <= wbyte[CR2_LADDER_BIT];
      time_reg <= wbyte[CR2_TIME_LSB +: 3];
    end
  end

  // Flag, result and interrupt; a completion outranks a same-cycle clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      eoc_reg <= 1'b0;
      result_reg <= {RES_RESET, RES_RESET[1:0]};
      irq_reg <= 1'b0;
      ladder_on_reg <= 1'b0;
    end else begin
      ladder_on_reg <= !STOP_MODE && (ladder_reg || seq_busy || start_fire);
      irq_reg <= store;
      if (STOP_MODE) begin
        eoc_reg <= 1'b0;
        result_reg <= {RES_RESET, RES_RESET[1:0]};
      end else if (store) begin
        eoc_reg <= 1'b1;
        result_reg <= seq_result;
      end else if (start_fire || rd_high) begin
        eoc_reg <= 1'b0;
      end
    end
  end

  sadc_sar_seq #(
    .RES_W(RES_W),
    .CNT_W(CONV_CNT_W),
    .PHASES(SAR_PHASES)
  ) u_seq (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start(start_fire),
    .abort(abort),
    .total(total_cyc),
    .comp(COMP_IN),
    .busy(seq_busy),
    .done(seq_done),
    .result(seq_result),
    .dac(seq_dac),
    .sample(seq_sample)
  );

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hreadyout_reg;
  assign HRESP = 1'b0;
  assign DAC_CODE = seq_dac;
  assign SAMPLE_HOLD = seq_sample;
  assign CHANNEL_SEL = chan_reg;
  assign ANALOG_INPUT_DISABLE = indis_reg;
  assign LADDER_CONNECT = ladder_on_reg;
  assign CONV_DONE_IRQ = irq_reg;

  // Helper: cycles the sequencer has been busy, and the time latched at start
  // A time write during a run must not upset the check
  logic [CONV_CNT_W-1:0] busy_cnt_reg, run_total_reg;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      busy_cnt_reg <= '0;
      run_total_reg <= '0;
    end else begin
      busy_cnt_reg <= seq_busy ? busy_cnt_reg + CONV_CNT_W'(1) : '0;
      if (start_fire) begin
        run_total_reg <= total_cyc;
      end
    end
  end

  property p_busy_on_start;
    @(posedge CLOCK) disable iff (!RST_N)
      start_fire |=> seq_busy && !start_req_reg;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("start did not set busy");

  property p_start_clear;
    @(posedge CLOCK) disable iff (!RST_N)
      (start_fire && start_req_reg) |=> !start_req_reg throughout seq_busy [*2];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared");

  property p_done_effects;
    @(posedge CLOCK) disable iff (!RST_N)
      store |=> eoc_reg && CONV_DONE_IRQ && result_reg == $past(seq_result) && !seq_busy || $past(start_fire);
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("completion effects missing");

  property p_stop_init;
    @(posedge CLOCK) disable iff (!RST_N)
      STOP_MODE |=> !seq_busy && !eoc_reg && mode_reg == MODE_DISABLE && result_reg == '0;
  endproperty
  a_stop_init: assert property (p_stop_init) else $error("STOP did not initialise");

  property p_ladder_stop;
    @(posedge CLOCK) disable iff (!RST_N)
      STOP_MODE |=> !LADDER_CONNECT;
  endproperty
  a_ladder_stop: assert property (p_ladder_stop) else $error("ladder left connected in STOP");

  property p_abort_keeps;
    @(posedge CLOCK) disable iff (!RST_N)
      (abort && !STOP_MODE) |=> $stable(result_reg) && !seq_busy ##1 !CONV_DONE_IRQ;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("aborted value stored");

  property p_repeat_next;
    @(posedge CLOCK) disable iff (!RST_N)
      (store && mode_reg == MODE_REPEAT) ##1 (mode_reg == MODE_REPEAT && !wr_cr1 && !STOP_MODE) |=> seq_busy;
  endproperty
  a_repeat_next: assert property (p_repeat_next) else $error("repeat did not restart");

  property p_read_clear;
    @(posedge CLOCK) disable iff (!RST_N)
      (rd_high && !store && !STOP_MODE) |=> !eoc_reg;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("high read left flag set");

  property p_conv_time;
    @(posedge CLOCK) disable iff (!RST_N)
      store |-> busy_cnt_reg == run_total_reg;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time wrong");

  property p_restart_keeps;
    @(posedge CLOCK) disable iff (!RST_N)
      (start_fire && !store) |=> !eoc_reg && $stable(result_reg);
  endproperty
  a_restart_keeps: assert property (p_restart_keeps) else $error("restart lost result");

  c_software_done: cover property (@(posedge CLOCK) disable iff (!RST_N)
    mode_reg == MODE_SOFTWARE && store);
  c_repeat_twice: cover property (@(posedge CLOCK) disable iff (!RST_N)
    store && mode_reg == MODE_REPEAT ##[1:200] store);
  c_abort: cover property (@(posedge CLOCK) disable iff (!RST_N) abort && !STOP_MODE);
  c_stop_busy: cover property (@(posedge CLOCK) disable iff (!RST_N) STOP_MODE && seq_busy);

endmodule

/* core/sadc_pkg.sv */
// Constants, register map and timing of the SAR converter control block
package sadc_pkg;

  // Register indices; byte address is index times four
  localparam int unsigned REG_WORD_BYTES = 4;
  localparam logic [7:0] IDX_CTRL_ONE = 8'h0E;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h0F;
  localparam logic [7:0] IDX_RES_HIGH = 8'h20;
  localparam logic [7:0] IDX_RES_LOW = 8'h21;

  // Field positions of control_reg_one
  localparam int unsigned CR1_START_BIT = 7;
  localparam int unsigned CR1_MODE_LSB = 5;
  localparam int unsigned CR1_INDIS_BIT = 4;
  localparam int unsigned CR1_CHAN_LSB = 0;

  // Field positions of control_reg_two
  localparam int unsigned CR2_LADDER_BIT = 5;
  localparam int unsigned CR2_FIXED_ONE_BIT = 4;
  localparam int unsigned CR2_TIME_LSB = 1;

  // Field positions of result_low_status_reg
  localparam int unsigned LOW_RES_LSB = 6;
  localparam int unsigned LOW_EOC_BIT = 5;
  localparam int unsigned LOW_BUSY_BIT = 4;

  // Reset values
  localparam logic [7:0] CR1_RESET = 8'h10;
  localparam logic [7:0] CR2_RESET = 8'h00;
  localparam logic [7:0] RES_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_DISABLE = 2'b00,
    MODE_SOFTWARE = 2'b01,
    MODE_RESERVED = 2'b10,
    MODE_REPEAT = 2'b11
  } sadc_mode_t;

  // Conversion times in fc periods; the block clock is fc itself
  localparam int unsigned CLK_PER_FC = 1;
  localparam int unsigned CONV_FC_T2 = 78;
  localparam int unsigned CONV_FC_T3 = 156;
  localparam int unsigned CONV_FC_T4 = 312;
  localparam int unsigned CONV_FC_T5 = 624;
  localparam int unsigned CONV_FC_T6 = 1248;
  localparam int unsigned SAR_PHASES = 11;
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned CONV_CNT_W = 11;

  localparam logic [CONV_CNT_W-1:0] CYC_T2 = CONV_CNT_W'(CONV_FC_T2 * CLK_PER_FC);
  localparam logic [CONV_CNT_W-1:0] CYC_T3 = CONV_CNT_W'(CONV_FC_T3 * CLK_PER_FC);
  localparam logic [CONV_CNT_W-1:0] CYC_T4 = CONV_CNT_W'(CONV_FC_T4 * CLK_PER_FC);
  localparam logic [CONV_CNT_W-1:0] CYC_T5 = CONV_CNT_W'(CONV_FC_T5 * CLK_PER_FC);
  localparam logic [CONV_CNT_W-1:0] CYC_T6 = CONV_CNT_W'(CONV_FC_T6 * CLK_PER_FC);

  // Reserved codes fall back to the longest time, the safe side for the analog part
  function automatic logic [CONV_CNT_W-1:0] conv_cycles(input logic [2:0] code);
    case (code)
      3'h2: conv_cycles = CYC_T2;
      3'h3: conv_cycles = CYC_T3;
      3'h4: conv_cycles = CYC_T4;
      3'h5: conv_cycles = CYC_T5;
      default: conv_cycles = CYC_T6;
    endcase
  endfunction

endpackage

/* core/sadc_sar_seq.sv */
// Successive-approximation sequencer: sample phase then ten bit decisions
`timescale 1ns/1ps
module sadc_sar_seq #(
  parameter int unsigned RES_W = 10,
  parameter int unsigned CNT_W = 11,
  parameter int unsigned PHASES = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [CNT_W-1:0] total,
  input wire logic comp,
  // Status and analog drive
  output logic busy,
  output logic done,
  output logic [RES_W-1:0] result,
  output logic [RES_W-1:0] dac,
  output logic sample
);

  if (RES_W < 2 || PHASES != RES_W + 1 || CNT_W < 8) begin : g_bad_params
    $error("sadc_sar_seq: unsupported parameter values");
  end

  typedef enum logic [1:0] {SQ_IDLE, SQ_SAMPLE, SQ_BITS, SQ_TAIL} sadc_seq_t;

  sadc_seq_t state_reg, state_next;
  logic [CNT_W-1:0] el_reg, tot_reg, step_reg, st_reg;
  localparam int unsigned BIT_W = $clog2(RES_W);
  logic [BIT_W-1:0] bit_reg;
  logic [RES_W-1:0] code_reg, code_next;
  logic busy_reg, done_reg, sample_reg;
  logic [RES_W-1:0] result_reg;

  wire step_end = (st_reg == step_reg - CNT_W'(1));
  wire last_cyc = (el_reg == tot_reg - CNT_W'(1));
  wire [RES_W-1:0] bit_mask = RES_W'(1) << bit_reg;

  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    if (abort) begin
      state_next = SQ_IDLE;
    end else begin
      case (state_reg)
        SQ_IDLE: if (start) begin
          state_next = SQ_SAMPLE;
          code_next = '0;
        end
        SQ_SAMPLE: if (step_end) begin
          state_next = SQ_BITS;
          code_next = RES_W'(1) << (RES_W - 1);
        end
        SQ_BITS: if (step_end) begin
          code_next = comp ? code_reg : (code_reg & ~bit_mask);
          if (bit_reg == '0) begin
            state_next = SQ_TAIL;
          end else begin
            code_next = code_next | (bit_mask >> 1);
          end
        end
        SQ_TAIL: ;
        default: state_next = SQ_IDLE;
      endcase
      if (state_reg != SQ_IDLE && last_cyc) begin
        state_next = SQ_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SQ_IDLE;
      el_reg <= '0;
      st_reg <= '0;
      tot_reg <= '0;
      step_reg <= '0;
      bit_reg <= '0;
      code_reg <= '0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      el_reg <= (state_reg == SQ_IDLE) ? '0 : el_reg + CNT_W'(1);
      st_reg <= (state_reg == SQ_IDLE || step_end) ? '0 : st_reg + CNT_W'(1);
      if (state_reg == SQ_IDLE && start) begin
        tot_reg <= total;
        step_reg <= CNT_W'(total / CNT_W'(PHASES));
        bit_reg <= BIT_W'(RES_W - 1);
      end else if (state_reg == SQ_BITS && step_end && bit_reg != '0) begin
        bit_reg <= bit_reg - BIT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      sample_reg <= 1'b0;
      result_reg <= '0;
    end else begin
      busy_reg <= (state_next != SQ_IDLE);
      sample_reg <= (state_next == SQ_SAMPLE);
      done_reg <= !abort && state_reg != SQ_IDLE && last_cyc;
      if (!abort && state_reg != SQ_IDLE && last_cyc) begin
        result_reg <= code_next;
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign result = result_reg;
  assign dac = code_reg;
  assign sample = sample_reg;

endmodule
